// >>> rtl/sdsr_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "sdsr_consts.svh"

module sdsr_top #(
   parameter sdsr_pkg::sdsr_mode_e MODE       = sdsr_pkg::SDSR_STD,
   parameter int                   XFER_W     = 8,
   parameter int                   FIFO_DEPTH = 16,
   parameter int                   NSLV       = 4
) (
   input  wire logic                           sys_clk,
   input  wire logic                           nrst,
   input  wire sdsr_pkg::sdsr_req_s            bus_req,
   output sdsr_pkg::sdsr_rsp_s                 bus_rsp,
   input  wire logic                           system_enable_bit,
   input  wire logic                           master_mode,
   input  wire logic                           ss_in_n,
   input  wire logic [`SDSR_HDR_W-1:0]         hdr_words,
   input  wire logic [`SDSR_DUMMY_W-1:0]       dummy_words,
   input  wire logic                           link_clk,
   input  wire logic                           lk_start,
   input  wire logic                           lk_done,
   input  wire logic [`SDSR_DATA_W-1:0]        lk_rx_data,
   output sdsr_pkg::sdsr_word_s                lk_tx,
   output logic                                lk_tx_valid,
   output logic [NSLV-1:0]                     ss_n,
   output logic [`SDSR_DUMMY_W-1:0]            rd_word_count,
   output logic                                tx_empty,
   output logic                                tx_full,
   output logic                                rx_empty,
   output logic                                rx_full,
   output logic                                rx_overrun,
   output logic                                rx_empty_read
);
   import sdsr_pkg::*;

   // ----------------------------------------------------------------
   // Configuration
   // ----------------------------------------------------------------
   // Multi-lane modes force byte words and an always-present FIFO
   localparam bit MULTI = (MODE != SDSR_STD);
   localparam int N     = MULTI ? `SDSR_MULTI_W : XFER_W;
   localparam int DEPTH = MULTI ?
      ((FIFO_DEPTH == `SDSR_DEPTH_LARGE) ? `SDSR_DEPTH_LARGE
                                         : `SDSR_DEPTH_SMALL) :
      ((FIFO_DEPTH == 0) ? 1 : FIFO_DEPTH);
   localparam int PW    = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW    = $clog2(DEPTH + 1);
   localparam logic [`SDSR_DATA_W-1:0] NMASK =
      (N >= `SDSR_DATA_W) ? {`SDSR_DATA_W{1'b1}}
                          : ((`SDSR_DATA_W'(1) << N) - `SDSR_DATA_W'(1));
   localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
   localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

   // ----------------------------------------------------------------
   // Storage and state
   // ----------------------------------------------------------------
   logic [`SDSR_DATA_W-1:0] tx_mem [DEPTH];
   logic [`SDSR_DATA_W-1:0] rx_mem [DEPTH];
   logic [PW-1:0]           tx_wr;
   logic [PW-1:0]           tx_rd;
   logic [PW-1:0]           rx_wr;
   logic [PW-1:0]           rx_rd;
   logic [CW-1:0]           tx_cnt;
   logic [CW-1:0]           rx_cnt;
   logic [NSLV-1:0]         ss_reg;
   logic                    in_flight;
   logic [`SDSR_IDX_W-1:0]  frame_idx;
   sdsr_word_s              mbox;
   logic                    mbox_tog;
   logic                    done_q;
   logic                    done_d;
   logic                    ss_in_q;
   logic                    done_tog;
   logic [`SDSR_DATA_W-1:0] rx_hold;

   // ----------------------------------------------------------------
   // Link crossing
   // ----------------------------------------------------------------
   sdsr_link u_link (
      .link_clk    (link_clk),
      .nrst        (nrst),
      .mbox        (mbox),
      .mbox_tog    (mbox_tog),
      .lk_start    (lk_start),
      .lk_done     (lk_done),
      .lk_rx_data  (lk_rx_data),
      .lk_tx       (lk_tx),
      .lk_tx_valid (lk_tx_valid),
      .rx_hold     (rx_hold),
      .done_tog    (done_tog)
   );

   // Completion toggle and the select pin come in through two flops
   sdsr_sync #(.W(2)) u_sync (
      .clk (sys_clk),
      .d   ({done_tog, ss_in_n}),
      .q   ({done_q, ss_in_q})
   );

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   wire hit_tx   = bus_req.valid && (bus_req.addr == `SDSR_TX_OFS);
   wire hit_rx   = bus_req.valid && (bus_req.addr == `SDSR_RX_OFS);
   wire hit_ss   = bus_req.valid && (bus_req.addr == `SDSR_SS_OFS);
   wire tx_is_fl = (tx_cnt == FULL_CNT);
   wire rx_is_fl = (rx_cnt == FULL_CNT);
   wire tx_is_mt = (tx_cnt == '0);
   wire rx_is_mt = (rx_cnt == '0);
   wire tx_push  = hit_tx && bus_req.we && !tx_is_fl;
   wire tx_bad   = hit_tx && bus_req.we && tx_is_fl;
   wire rx_pop   = hit_rx && !bus_req.we && !rx_is_mt;
   wire rx_bad   = hit_rx && !bus_req.we && rx_is_mt;
   wire done_evt = done_q ^ done_d;
   wire tx_pop   = done_evt && in_flight;
   wire rx_push  = done_evt && !rx_is_fl;
   wire rx_drop  = done_evt && rx_is_fl;

   // Master waits for the enable bit, slave for its select pin
   wire xfer_en  = master_mode ? system_enable_bit : !ss_in_q;
   wire send     = xfer_en && !in_flight && !tx_is_mt;

   // Frame ends when no select line is active in either role
   wire frame_off = master_mode ? (&ss_reg) : ss_in_q;

   // In multi-lane modes, words in the dummy window go out quiet; sizes are software's job
   wire [`SDSR_IDX_W-1:0] hdr_end   = `SDSR_IDX_W'(hdr_words);
   wire [`SDSR_IDX_W-1:0] dummy_end = hdr_end + `SDSR_IDX_W'(dummy_words);
   wire send_quiet = MULTI && (frame_idx >= hdr_end)
                     && (frame_idx < dummy_end);

   // Low bits only; upper lanes reserved and forced to zero
   wire [`SDSR_DATA_W-1:0] tx_in   = bus_req.wdata & NMASK;
   wire [`SDSR_DATA_W-1:0] rx_in   = rx_hold & NMASK;

   // Select write accepted only if at most one line would go low
   wire [NSLV-1:0] ss_w     = bus_req.wdata[NSLV-1:0];
   wire [NSLV-1:0] ss_low   = ~ss_w;
   wire            ss_onehot = ((ss_low & (ss_low - NSLV'(1))) == '0);
   wire            ss_write = hit_ss && bus_req.we && ss_onehot;

   // Read data and response selection
   wire [`SDSR_DATA_W-1:0] ss_rd = `SDSR_DATA_W'(ss_reg);
   wire [`SDSR_DATA_W-1:0] rd_mux =
      hit_rx ? (rx_is_mt ? '0 : rx_mem[rx_rd]) :
      hit_ss ? ss_rd : `SDSR_TX_UNDEF;
   wire [1:0] resp_mux =
      (tx_bad || (rx_bad && !MULTI)) ? `SDSR_RESP_SLVERR
                                     : `SDSR_RESP_OKAY;

   // ----------------------------------------------------------------
   // Bus answer
   // ----------------------------------------------------------------
   // One-cycle registered answer to every request, mapped or not
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         bus_rsp <= '0;
      end else begin
         bus_rsp.ack   <= bus_req.valid;
         bus_rsp.resp  <= bus_req.valid ? resp_mux : `SDSR_RESP_OKAY;
         bus_rsp.rdata <= (bus_req.valid && !bus_req.we) ? rd_mux : '0;
      end
   end

   // ----------------------------------------------------------------
   // Transmit FIFO
   // ----------------------------------------------------------------
   // Storage itself needs no reset; pointers decide validity
   always_ff @(posedge sys_clk) begin
      if (tx_push) begin
         tx_mem[tx_wr] <= tx_in;
      end
   end

   // Pointers; the head stays until its transfer completes
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         tx_wr <= '0;
         tx_rd <= '0;
      end else begin
         if (tx_push) begin
            tx_wr <= (tx_wr == LAST_PTR) ? '0 : tx_wr + PW'(1);
         end
         if (tx_pop) begin
            tx_rd <= (tx_rd == LAST_PTR) ? '0 : tx_rd + PW'(1);
         end
      end
   end

   // Occupancy; a write always leaves the FIFO non-empty
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         tx_cnt <= '0;
      end else if (tx_push && !tx_pop) begin
         tx_cnt <= tx_cnt + CW'(1);
      end else if (tx_pop && !tx_push) begin
         tx_cnt <= tx_cnt - CW'(1);
      end
   end

   // ----------------------------------------------------------------
   // Hand-off to the link
   // ----------------------------------------------------------------
   // Mailbox only changes after the previous word completed, so it
   // stays stable for the link side while its request is pending
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         mbox      <= '0;
         mbox_tog  <= 1'b0;
         in_flight <= 1'b0;
      end else if (send) begin
         mbox.quiet <= send_quiet;
         mbox.data  <= tx_mem[tx_rd] & NMASK;
         mbox_tog   <= ~mbox_tog;
         in_flight  <= 1'b1;
      end else if (tx_pop) begin
         in_flight <= 1'b0;
      end
   end

   // Word index within the current frame, saturating
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         frame_idx <= '0;
      end else if (frame_off) begin
         frame_idx <= '0;
      end else if (send && !(&frame_idx)) begin
         frame_idx <= frame_idx + `SDSR_IDX_W'(1);
      end
   end

   // ----------------------------------------------------------------
   // Receive FIFO
   // ----------------------------------------------------------------
   // Unreset storage: a slot is valid only after a word lands in it
   always_ff @(posedge sys_clk) begin
      if (rx_push) begin
         rx_mem[rx_wr] <= rx_in;
      end
   end

   // Completion edge detector reads the synchronised copy only
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         done_d <= 1'b0;
      end else begin
         done_d <= done_q;
      end
   end

   // Pointers
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         rx_wr <= '0;
         rx_rd <= '0;
      end else begin
         if (rx_push) begin
            rx_wr <= (rx_wr == LAST_PTR) ? '0 : rx_wr + PW'(1);
         end
         if (rx_pop) begin
            rx_rd <= (rx_rd == LAST_PTR) ? '0 : rx_rd + PW'(1);
         end
      end
   end

   // Occupancy; a read in the same cycle as a push nets out
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         rx_cnt <= '0;
      end else if (rx_push && !rx_pop) begin
         rx_cnt <= rx_cnt + CW'(1);
      end else if (rx_pop && !rx_push) begin
         rx_cnt <= rx_cnt - CW'(1);
      end
   end

   // ----------------------------------------------------------------
   // Select vector
   // ----------------------------------------------------------------
   // All lines deselected from reset; bad patterns are refused
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         ss_reg <= NSLV'(`SDSR_SS_RESET);
      end else if (ss_write) begin
         ss_reg <= ss_w;
      end
   end

   // Bit k drives line k
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         ss_n <= NSLV'(`SDSR_SS_RESET);
      end else begin
         ss_n <= ss_reg;
      end
   end

   // ----------------------------------------------------------------
   // Status and events
   // ----------------------------------------------------------------
   // Empty/full levels follow occupancy, rd_word_count follows dummy_words in multi-lane modes; pulses last one cycle
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         tx_empty      <= 1'b1;
         tx_full       <= 1'b0;
         rx_empty      <= 1'b1;
         rx_full       <= 1'b0;
         rx_overrun    <= 1'b0;
         rx_empty_read <= 1'b0;
         rd_word_count <= '0;
      end else begin
         tx_empty      <= tx_is_mt;
         tx_full       <= tx_is_fl;
         rx_empty      <= rx_is_mt;
         rx_full       <= rx_is_fl;
         rx_overrun    <= rx_drop;
         rx_empty_read <= rx_bad;
         rd_word_count <= MULTI ? dummy_words : '0;
      end
   end

endmodule : sdsr_top

`default_nettype wire

// >>> common/sdsr_consts.svh
`ifndef SDSR_CONSTS_SVH
`define SDSR_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define SDSR_ADDR_W        8
`define SDSR_DATA_W        32
`define SDSR_TX_OFS        8'h68
`define SDSR_RX_OFS        8'h6c
`define SDSR_SS_OFS        8'h70

// ----------------------------------------------------------------
// Bus answers and reset values
// ----------------------------------------------------------------
`define SDSR_RESP_OKAY     2'h0
`define SDSR_RESP_SLVERR   2'h2
`define SDSR_SS_RESET      32'hffffffff
`define SDSR_TX_UNDEF      32'h00000000

// ----------------------------------------------------------------
// Widths and depths
// ----------------------------------------------------------------
`define SDSR_MULTI_W       8
`define SDSR_DEPTH_SMALL   16
`define SDSR_DEPTH_LARGE   256
`define SDSR_IDX_W         9
`define SDSR_HDR_W         4
`define SDSR_DUMMY_W       8

`endif

// >>> common/sdsr_pkg.sv
package sdsr_pkg;
`include "sdsr_consts.svh"

   // Lane modes; Gray coded along std -> dual -> quad
   typedef enum logic [1:0] {
      SDSR_STD  = 2'h0,
      SDSR_DUAL = 2'h1,
      SDSR_QUAD = 2'h3
   } sdsr_mode_e;

   // One register access request
   typedef struct packed {
      logic                    valid;
      logic                    we;
      logic [`SDSR_ADDR_W-1:0] addr;
      logic [`SDSR_DATA_W-1:0] wdata;
   } sdsr_req_s;

   // Registered answer to a request
   typedef struct packed {
      logic                    ack;
      logic [1:0]              resp;
      logic [`SDSR_DATA_W-1:0] rdata;
   } sdsr_rsp_s;

   // Word handed to the shift engine
   typedef struct packed {
      logic                    quiet;
      logic [`SDSR_DATA_W-1:0] data;
   } sdsr_word_s;

endpackage : sdsr_pkg

// >>> rtl/sdsr_sync.sv
`timescale 1ns/100ps
`default_nettype none

// Two flip-flop level synchroniser, one chain per bit
module sdsr_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta;

   // ----------------------------------------------------------------
   // Chains
   // ----------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         // First stage feeds only the second stage
         always_ff @(posedge clk) begin
            meta[i] <= d[i];
            q[i]    <= meta[i];
         end
      end
   endgenerate

endmodule : sdsr_sync

`default_nettype wire

// >>> rtl/sdsr_link.sv
`timescale 1ns/100ps
`default_nettype none
`include "sdsr_consts.svh"

// Link-clock end: mailbox toward the shift engine, receive hold back
module sdsr_link (
   input  wire logic                           link_clk,
   input  wire logic                           nrst,
   input  wire sdsr_pkg::sdsr_word_s           mbox,
   input  wire logic                           mbox_tog,
   input  wire logic                           lk_start,
   input  wire logic                           lk_done,
   input  wire logic [`SDSR_DATA_W-1:0]        lk_rx_data,
   output sdsr_pkg::sdsr_word_s                lk_tx,
   output logic                                lk_tx_valid,
   output logic [`SDSR_DATA_W-1:0]             rx_hold,
   output logic                                done_tog
);
   import sdsr_pkg::*;

   logic lk_nrst;
   logic req_q;
   logic taken_tog;

   // ----------------------------------------------------------------
   // Crossings into the link domain
   // ----------------------------------------------------------------
   sdsr_sync #(.W(2)) u_sync (
      .clk (link_clk),
      .d   ({nrst, mbox_tog}),
      .q   ({lk_nrst, req_q})
   );

   // Mailbox is stable while a request is pending, so sampling is safe
   assign lk_tx_valid = req_q ^ taken_tog;

   // ----------------------------------------------------------------
   // Load at transfer start, capture at transfer end
   // ----------------------------------------------------------------
   // Pending word enters the shift path only when a new transfer starts
   always_ff @(posedge link_clk) begin
      if (!lk_nrst) begin
         taken_tog <= 1'b0;
         lk_tx     <= '0;
      end else if (lk_start && lk_tx_valid) begin
         taken_tog <= ~taken_tog;
         lk_tx     <= mbox;
      end
   end

   // Received word held stable until the next completed transfer
   always_ff @(posedge link_clk) begin
      if (!lk_nrst) begin
         done_tog <= 1'b0;
         rx_hold  <= '0;
      end else if (lk_done) begin
         done_tog <= ~done_tog;
         rx_hold  <= lk_rx_data;
      end
   end

endmodule : sdsr_link

`default_nettype wire

// >>> bench/sdsr_chk_props.sv
`timescale 1ns/100ps
`default_nettype none
`include "sdsr_consts.svh"

// ----------
// Port checker for the data and select path
// ----------
module sdsr_chk #(
   parameter int NSLV = 4
) (
   input  wire logic                 sys_clk,
   input  wire logic                 nrst,
   input  wire sdsr_pkg::sdsr_req_s  bus_req,
   input  wire sdsr_pkg::sdsr_rsp_s  bus_rsp,
   input  wire logic                 link_clk,
   input  wire logic                 lk_start,
   input  wire sdsr_pkg::sdsr_word_s lk_tx,
   input  wire logic                 lk_tx_valid,
   input  wire logic [NSLV-1:0]      ss_n,
   input  wire logic                 tx_empty,
   input  wire logic                 rx_full,
   input  wire logic                 rx_overrun,
   input  wire logic                 rx_empty_read
);
   import sdsr_pkg::*;

   // Request decodes shared by the properties
   wire logic req = bus_req.valid;
   wire logic wr_tx = req && bus_req.we && bus_req.addr == `SDSR_TX_OFS;
   wire logic rd_tx = req && !bus_req.we && bus_req.addr == `SDSR_TX_OFS;
   wire logic wr_rx = req && bus_req.we && bus_req.addr == `SDSR_RX_OFS;
   wire logic wr_ss = req && bus_req.we && bus_req.addr == `SDSR_SS_OFS;
   wire logic rd_ss = req && !bus_req.we && bus_req.addr == `SDSR_SS_OFS;

   a_rx_write_okay: assert property (
      @(posedge sys_clk) disable iff (!nrst) wr_rx |=> bus_rsp.ack &&
      bus_rsp.resp == `SDSR_RESP_OKAY) else $error("rx write not okay");
   a_tx_read_zero: assert property (
      @(posedge sys_clk) disable iff (!nrst) rd_tx |=> bus_rsp.ack &&
      bus_rsp.rdata == 32'h0) else $error("tx read not zero");
   a_empty_read_err: assert property (
      @(posedge sys_clk) disable iff (!nrst) rx_empty_read |-> bus_rsp.ack
      && bus_rsp.resp == `SDSR_RESP_SLVERR) else $error("empty read okay");
   a_ss_one_hot: assert property (
      @(posedge sys_clk) disable iff (!nrst) $onehot0(~ss_n))
      else $error("two selects low");
   a_ss_reset_high: assert property (
      @(posedge sys_clk) disable iff (!nrst) $rose(nrst) |-> &ss_n)
      else $error("select not reset high");
   a_ss_write_lands: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      wr_ss && $onehot0(~bus_req.wdata[NSLV-1:0])
      |-> ##2 ss_n == $past(bus_req.wdata[NSLV-1:0], 2))
      else $error("select lost");
   a_ss_read_back: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      rd_ss |=> bus_rsp.rdata == 32'(ss_n)) else $error("select readback");
   a_tx_empty_clr: assert property (
      @(posedge sys_clk) disable iff (!nrst) wr_tx ##1 (bus_rsp.ack &&
      bus_rsp.resp == `SDSR_RESP_OKAY) |-> ##[1:2] !tx_empty)
      else $error("tx empty stuck");
   a_overrun_full: assert property (
      @(posedge sys_clk) disable iff (!nrst) rx_overrun |-> rx_full)
      else $error("overrun while not full");
   a_lk_tx_hold: assert property (
      @(posedge link_clk) disable iff (!nrst)
      !(lk_start && lk_tx_valid) |=> $stable(lk_tx))
      else $error("shift word moved");

   // Main scenarios reached
   c_overrun: cover property (@(posedge sys_clk) rx_overrun);
   c_refused: cover property (@(posedge sys_clk)
      wr_tx ##1 bus_rsp.resp == `SDSR_RESP_SLVERR);
   c_taken: cover property (@(posedge link_clk) lk_start && lk_tx_valid);
endmodule : sdsr_chk

`default_nettype wire

// >>> bench/sdsr_far.sv
`timescale 1ns/100ps
`default_nettype none

// Far-end shift engine: takes each offered word, answers a non-quiet one with its inverse
module sdsr_far (
   input  wire logic                 link_clk,
   input  wire logic                 nrst,
   input  wire logic                 slow,
   input  wire sdsr_pkg::sdsr_word_s lk_tx,
   input  wire logic                 lk_tx_valid,
   output logic                      lk_start,
   output logic                      lk_done,
   output logic [31:0]               lk_rx_data,
   output sdsr_pkg::sdsr_word_s      taken
);
   import sdsr_pkg::*;
   int cnt;

   // One word per start/done pair; data line inverts once its hold ends
   always @(posedge link_clk) begin
      lk_start <= 1'b0;
      lk_done  <= 1'b0;
      if (!nrst) begin
         cnt        <= 0;
         taken      <= '0;
         lk_rx_data <= 32'hffffffff;
      end else if (cnt == 0) begin
         if (lk_tx_valid === 1'b1) begin
            lk_start <= 1'b1;
            cnt      <= 1;
         end
      end else begin
         cnt <= cnt + 1;
         if (cnt == 2)
            taken <= lk_tx;
         if (cnt == (slow ? 8 : 3)) begin
            lk_done    <= 1'b1;
            // Dummy replies are junk that software drops
            lk_rx_data <= lk_tx.quiet ? ~lk_rx_data : ~lk_tx.data;
         end
         if (cnt == (slow ? 9 : 4)) begin
            lk_rx_data <= ~lk_rx_data;
            cnt        <= 0;
         end
      end
   end
endmodule : sdsr_far

`default_nettype wire

// >>> bench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "sdsr_consts.svh"

module tb_top;
   import sdsr_pkg::*;
   localparam int NSLV = 4;
   typedef struct packed {
      logic we; logic [7:0] addr; logic [31:0] wdata;
      logic [1:0] resp; logic [31:0] rdata;
   } sdsr_row_s;
   logic sys_clk, link_clk, nrst, system_enable_bit, master_mode;
   logic ss_in_n, slow, ovr_seen;
   sdsr_req_s bus_req;
   sdsr_rsp_s bus_rsp, rsp;
   sdsr_word_s lk_tx, taken;
   wire logic lk_start, lk_done, lk_tx_valid, tx_empty, tx_full;
   wire logic rx_empty, rx_full, rx_overrun, rx_empty_read;
   wire logic [31:0] lk_rx_data;
   wire logic [NSLV-1:0] ss_n;
   int errors, samples_checked;
   // Plain accesses: select, reserved places, empty receive, unmapped
   sdsr_row_s rows [10] = '{
      '{1'b0, 8'h70, 32'h0, 2'h0, 32'hf}, '{1'b1, 8'h70, 32'he, 2'h0, 32'h0},
      '{1'b0, 8'h70, 32'h0, 2'h0, 32'he}, '{1'b1, 8'h70, 32'h5, 2'h0, 32'h0},
      '{1'b0, 8'h70, 32'h0, 2'h0, 32'he}, '{1'b1, 8'h6c, 32'h77, 2'h0, 32'h0},
      '{1'b0, 8'h6c, 32'h0, 2'h2, 32'h0}, '{1'b0, 8'h68, 32'h0, 2'h0, 32'h0},
      '{1'b0, 8'h00, 32'h0, 2'h0, 32'h0}, '{1'b1, 8'h70, 32'hf, 2'h0, 32'h0}};

   sdsr_top #(.MODE(SDSR_STD), .XFER_W(8), .FIFO_DEPTH(0), .NSLV(NSLV))
   i_sdsr_top (.sys_clk(sys_clk), .nrst(nrst), .bus_req(bus_req),
      .bus_rsp(bus_rsp), .system_enable_bit(system_enable_bit),
      .master_mode(master_mode), .ss_in_n(ss_in_n), .hdr_words(4'h0),
      .dummy_words(8'h0), .link_clk(link_clk), .lk_start(lk_start),
      .lk_done(lk_done), .lk_rx_data(lk_rx_data), .lk_tx(lk_tx),
      .lk_tx_valid(lk_tx_valid), .ss_n(ss_n), .rd_word_count(),
      .tx_empty(tx_empty), .tx_full(tx_full), .rx_empty(rx_empty),
      .rx_full(rx_full), .rx_overrun(rx_overrun),
      .rx_empty_read(rx_empty_read));

   sdsr_far i_sdsr_far (.link_clk(link_clk), .nrst(nrst), .slow(slow),
      .lk_tx(lk_tx), .lk_tx_valid(lk_tx_valid), .lk_start(lk_start),
      .lk_done(lk_done), .lk_rx_data(lk_rx_data), .taken(taken));

   // Clocks: link clock free-running so its reset synchroniser advances
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   initial begin
      link_clk = 1'b0;
      #37.3;
      forever #80 link_clk = ~link_clk;
   end
   // Overrun is a one-cycle pulse, so keep a sticky copy
   always @(posedge sys_clk)
      ovr_seen <= nrst && (ovr_seen || rx_overrun === 1'b1);

   task check(input logic [34:0] seen, input logic [34:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task idle(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : idle

   // Held one edge, answer taken just after the following edge
   task bus(input logic we, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      bus_req <= '{1'b1, we, a, d};
      @(posedge sys_clk);
      bus_req.valid <= 1'b0;
      #1 rsp = bus_rsp;
   endtask : bus

   task wait_rx;
      int i;
      for (i = 0; i < 1000 && rx_empty !== 1'b0; i++)
         idle(1);
      check(rx_empty, 1'b0);
   endtask : wait_rx

   task finish_test;
      $display("errors=%0d samples_checked=%0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : finish_test

   initial begin
      #100000;
      errors++;
      finish_test();
   end

   initial begin
      {nrst, system_enable_bit, ss_in_n, slow} = 4'b0010;
      master_mode = 1'b1;
      bus_req = '0;
      errors = 0;
      samples_checked = 0;
      repeat (5) @(posedge link_clk);
      @(posedge sys_clk) nrst <= 1'b1;
      #1 check({ss_n, tx_empty, rx_empty}, 6'h3f);
      foreach (rows[k]) begin
         bus(rows[k].we, rows[k].addr, rows[k].wdata);
         check({rsp.ack, rsp.resp, rsp.rdata},
               {1'b1, rows[k].resp, rows[k].rdata});
      end
      // Disabled master holds the word; a second write is refused
      bus(1'b1, `SDSR_TX_OFS, 32'h123456a5);
      bus(1'b1, `SDSR_TX_OFS, 32'h5a);
      check(rsp.resp, `SDSR_RESP_SLVERR);
      idle(300);
      check({tx_full, tx_empty, taken}, 35'h4_0000_0000);
      @(posedge sys_clk) system_enable_bit <= 1'b1;
      wait_rx();
      check({taken.quiet, taken.data[7:0]}, 9'ha5);
      bus(1'b0, `SDSR_RX_OFS, 32'h0);
      check({rsp.resp, rsp.rdata}, 34'h5a);
      check(tx_empty, 1'b1);
      // Unread word blocks the next; second reply is dropped
      bus(1'b1, `SDSR_TX_OFS, 32'h11);
      wait_rx();
      bus(1'b1, `SDSR_TX_OFS, 32'h22);
      for (int i = 0; i < 1000 && ovr_seen !== 1'b1; i++)
         idle(1);
      check(ovr_seen, 1'b1);
      bus(1'b0, `SDSR_RX_OFS, 32'h0);
      check(rsp.rdata, 32'hee);
      bus(1'b0, `SDSR_RX_OFS, 32'h0);
      check({rsp.resp, rx_empty_read}, 3'h5);
      // Slave mode with a slow far end waits for its select pin
      @(posedge sys_clk) master_mode <= 1'b0;
      slow <= 1'b1;
      bus(1'b1, `SDSR_TX_OFS, 32'h33);
      idle(300);
      check(tx_empty, 1'b0);
      @(posedge sys_clk) ss_in_n <= 1'b0;
      wait_rx();
      bus(1'b0, `SDSR_RX_OFS, 32'h0);
      check(rsp.rdata, 32'hcc);
      // Reset in mid-run deselects every slave
      bus(1'b1, `SDSR_SS_OFS, 32'hb);
      @(posedge sys_clk) nrst <= 1'b0;
      repeat (5) @(posedge link_clk);
      @(posedge sys_clk) nrst <= 1'b1;
      bus(1'b0, `SDSR_SS_OFS, 32'h0);
      check(rsp.rdata, 32'hf);
      finish_test();
   end
endmodule : tb_top

bind sdsr_top sdsr_chk #(.NSLV(NSLV)) i_sdsr_chk (.sys_clk(sys_clk),
   .nrst(nrst), .bus_req(bus_req), .bus_rsp(bus_rsp), .link_clk(link_clk),
   .lk_start(lk_start), .lk_tx(lk_tx), .lk_tx_valid(lk_tx_valid),
   .ss_n(ss_n), .tx_empty(tx_empty), .rx_full(rx_full),
   .rx_overrun(rx_overrun), .rx_empty_read(rx_empty_read));

`default_nettype wire
